//--- sdms_pkg.sv
// shared constants and carrier types of the step/dir microstep sequencer
// assumes a single 250 MHz clock domain
package sdms_pkg;
    // ======================================================
    // register map, byte addresses
    localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] REG_POSITION = 4'h8;
    localparam logic [3:0] REG_STRAPS = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ======================================================
    // interrupt bits
    localparam int IRQ_BITS = 3;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_INDEX = 1;
    localparam int IRQ_STANDBY = 2;
    // ======================================================
    // motion and current constants
    localparam int POS_W = 10;
    localparam logic [8:0] STEP_FULL = 9'h100;
    localparam logic [3:0] RES_MAX_CODE = 4'h8;
    localparam logic [8:0] SCALE_FULL = 9'h100;
    localparam logic [8:0] SCALE_MIN = 9'h057;
    localparam int STANDBY_DELAY_CYCLES = 3000000;
    localparam int RAMP_TOTAL_CYCLES = 44000000;
    localparam int CLK_DETECT_CYCLES = 64;
    localparam int SYNC_W = 13;
    // ======================================================
    // carriers
    typedef struct packed {
        logic neg;
        logic [7:0] mag;
    } sdms_coil_t;
    typedef struct packed {
        logic short_out;
        logic over_temp;
        logic under_volt;
    } sdms_fault_t;
    typedef struct packed {
        logic disable_drv;
        logic [5:0] cfg;
    } sdms_strap_t;
endpackage

//--- sdms_sequencer.sv
// step/dir microstep sequencer with standstill reduction and AXI4-Lite status
// assumes all pins asynchronous to aclk; analog blocks report faults as levels
//
// Overview of operation
// - only rising step edges move the position
// - way-select sampled at each active step edge
// - full step or 2..256 microsteps per step
// - low way-select counts up, high down
// - table maps counter to sine/cosine coil setpoints
// - standby starts after 3M idle cycles, enabled
// - current ramps softly 100% to 34% in 44M
// - configuration from seven strap inputs, interrupt mask written over AXI4-Lite
// - internal oscillator unless external clock toggles
// - two status outputs for external controller
// - shorts, overtemperature, undervoltage disable the driver
// - open-drain fault output from error until disable strap clears it
// - open-drain index output at table position
// - disable strap high turns motor outputs off
`timescale 1ns/1ps
`default_nettype none
module sdms_sequencer #(
    parameter int STANDBY_DELAY = sdms_pkg::STANDBY_DELAY_CYCLES,
    parameter int RAMP_TOTAL = sdms_pkg::RAMP_TOTAL_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic ext_clk_pin,
    input wire sdms_pkg::sdms_strap_t strap_pins,
    input wire sdms_pkg::sdms_fault_t fault_pins,
    output sdms_pkg::sdms_coil_t coil_a,
    output sdms_pkg::sdms_coil_t coil_b,
    output logic drive_enable,
    output logic ext_clock_sel,
    output logic error_out,
    output logic error_oe,
    output logic index_out,
    output logic index_oe,
    output logic irq
);
    localparam int RAMP_STEP = RAMP_TOTAL / 32'(sdms_pkg::SCALE_FULL - sdms_pkg::SCALE_MIN);

    // ======================================================
    // input synchronisers
    logic [sdms_pkg::SYNC_W-1:0] sync1;
    logic [sdms_pkg::SYNC_W-1:0] sync2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {step_pin, dir_pin, ext_clk_pin, strap_pins, fault_pins};
            sync2 <= sync1;
        end
    end
    logic step_s, dir_s, ext_s;
    sdms_pkg::sdms_strap_t strap_s;
    sdms_pkg::sdms_fault_t fault_s;
    assign {step_s, dir_s, ext_s, strap_s, fault_s} = sync2;

    // ======================================================
    // step edge and resolution
    logic step_prev;
    always_ff @(posedge aclk) begin
        if (!aresetn) step_prev <= 1'b0;
        else step_prev <= step_s;
    end
    logic step_rise;
    assign step_rise = step_s && !step_prev;

    logic [3:0] res_code;
    logic [8:0] incr;
    assign res_code = strap_s.cfg[3:0];
    always_comb begin
        if (res_code == 4'h0) incr = sdms_pkg::STEP_FULL;
        else if (res_code <= sdms_pkg::RES_MAX_CODE) incr = sdms_pkg::STEP_FULL >> res_code;
        else incr = 9'h001;
    end

    // ======================================================
    // microstep counter
    logic [sdms_pkg::POS_W-1:0] position;
    always_ff @(posedge aclk) begin
        if (!aresetn) position <= '0;
        else if (step_rise) begin
            if (!dir_s) position <= position + 10'(incr);
            else position <= position - 10'(incr);
        end
    end

    // ======================================================
    // standstill reduction
    logic [31:0] idle_cnt;
    logic [31:0] ramp_cnt;
    logic [8:0] scale;
    logic standby;
    assign standby = strap_s.cfg[4] && (idle_cnt > 32'(STANDBY_DELAY));
    always_ff @(posedge aclk) begin
        if (!aresetn) idle_cnt <= '0;
        else if (step_rise) idle_cnt <= '0;
        else if (idle_cnt <= 32'(STANDBY_DELAY)) idle_cnt <= idle_cnt + 32'h0000_0001;
    end
    // one scale unit per ramp step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scale <= sdms_pkg::SCALE_FULL;
            ramp_cnt <= '0;
        end else if (!standby) begin
            scale <= sdms_pkg::SCALE_FULL;
            ramp_cnt <= '0;
        end else if (scale > sdms_pkg::SCALE_MIN) begin
            if (ramp_cnt >= 32'(RAMP_STEP - 1)) begin
                ramp_cnt <= '0;
                scale <= scale - 9'h001;
            end else begin
                ramp_cnt <= ramp_cnt + 32'h0000_0001;
            end
        end
    end

    // ======================================================
    // sine table and coil setpoints
    function automatic logic [7:0] quarter_sine(input logic [4:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            5'd0: v = 8'h00;
            5'd1: v = 8'h19;
            5'd2: v = 8'h32;
            5'd3: v = 8'h4A;
            5'd4: v = 8'h62;
            5'd5: v = 8'h79;
            5'd6: v = 8'h8E;
            5'd7: v = 8'hA2;
            5'd8: v = 8'hB5;
            5'd9: v = 8'hC6;
            5'd10: v = 8'hD5;
            5'd11: v = 8'hE2;
            5'd12: v = 8'hED;
            5'd13: v = 8'hF5;
            5'd14: v = 8'hFB;
            default: v = 8'hFF;
        endcase
        return v;
    endfunction
    function automatic sdms_pkg::sdms_coil_t table_at(input logic [9:0] p, input logic [8:0] s);
        logic [4:0] idx;
        logic [16:0] prod;
        sdms_pkg::sdms_coil_t c;
        idx = p[8] ? 5'd16 - {1'b0, p[7:4]} : {1'b0, p[7:4]};
        prod = quarter_sine(idx) * s;
        c.neg = p[9];
        c.mag = prod[15:8];
        return c;
    endfunction

    logic fault_latched;
    logic run;
    assign run = !strap_s.disable_drv && !fault_latched;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coil_a <= '0;
            coil_b <= '0;
            drive_enable <= 1'b0;
        end else begin
            coil_a <= run ? table_at(position, scale) : '0;
            coil_b <= run ? table_at(position + 10'h100, scale) : '0;
            drive_enable <= run;
        end
    end

    // ======================================================
    // protection and status pins
    // latch fault, clear by disable strap
    always_ff @(posedge aclk) begin
        if (!aresetn) fault_latched <= 1'b0;
        else if (|fault_s) fault_latched <= 1'b1;
        else if (strap_s.disable_drv) fault_latched <= 1'b0;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_oe <= 1'b0;
            index_oe <= 1'b0;
            error_out <= 1'b0;
            index_out <= 1'b0;
        end else begin
            error_oe <= fault_latched;
            index_oe <= (position == '0);
            error_out <= 1'b0;
            index_out <= 1'b0;
        end
    end

    // ======================================================
    // clock source detect
    logic ext_prev;
    logic [6:0] clk_quiet;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev <= 1'b0;
            clk_quiet <= '0;
            ext_clock_sel <= 1'b0;
        end else begin
            ext_prev <= ext_s;
            if (ext_s != ext_prev) begin
                clk_quiet <= '0;
                ext_clock_sel <= 1'b1;
            end else if (clk_quiet >= 7'(sdms_pkg::CLK_DETECT_CYCLES)) begin
                ext_clock_sel <= 1'b0;
            end else begin
                clk_quiet <= clk_quiet + 7'h01;
            end
        end
    end

    // ======================================================
    // interrupts
    logic [sdms_pkg::IRQ_BITS-1:0] irq_status, irq_mask, irq_set, irq_clr;
    logic standby_prev, index_prev;
    logic wr_fire;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_strb0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_prev <= 1'b0;
            index_prev <= 1'b0;
        end else begin
            standby_prev <= standby;
            index_prev <= (position == '0);
        end
    end
    always_comb begin
        irq_set = '0;
        irq_set[sdms_pkg::IRQ_FAULT] = (|fault_s) && !fault_latched;
        irq_set[sdms_pkg::IRQ_INDEX] = (position == '0) && !index_prev;
        irq_set[sdms_pkg::IRQ_STANDBY] = standby && !standby_prev;
        irq_clr = '0;
        if (wr_fire && wr_addr == sdms_pkg::REG_IRQ_STATUS && wr_strb0)
            irq_clr = wr_data[sdms_pkg::IRQ_BITS-1:0];
    end
    // set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) irq_status <= '0;
        else irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) irq_mask <= '0;
        else if (wr_fire && wr_addr == sdms_pkg::REG_IRQ_MASK && wr_strb0)
            irq_mask <= wr_data[sdms_pkg::IRQ_BITS-1:0];
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else irq <= |(irq_status & irq_mask);
    end

    // ======================================================
    // AXI4-Lite write channel
    logic aw_got, w_got;
    assign wr_fire = aw_got && w_got && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sdms_pkg::RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= s_axi_awaddr;
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data <= s_axi_wdata;
                wr_strb0 <= s_axi_wstrb[0];
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr == sdms_pkg::REG_IRQ_STATUS
                    || wr_addr == sdms_pkg::REG_IRQ_MASK) ? sdms_pkg::RESP_OKAY
                    : sdms_pkg::RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ======================================================
    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= sdms_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sdms_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sdms_pkg::REG_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
                sdms_pkg::REG_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
                sdms_pkg::REG_POSITION: s_axi_rdata <= {7'h00, scale, 6'h00, position};
                sdms_pkg::REG_STRAPS: s_axi_rdata <= {22'h00_0000, fault_latched,
                    ext_clock_sel, drive_enable, strap_s};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= sdms_pkg::RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ======================================================
    // assertions
    property p_rise_only;
        @(posedge aclk) disable iff (!aresetn) !step_rise |=> $stable(position);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("position moved without rising step");
    property p_dir_back;
        @(posedge aclk) disable iff (!aresetn)
            step_rise && dir_s |=> position == $past(position) - 10'($past(incr));
    endproperty
    a_dir_back: assert property (p_dir_back) else $error("high way-select did not count down");
    property p_res_full;
        @(posedge aclk) disable iff (!aresetn) res_code == 4'h0 |-> incr == 9'h100;
    endproperty
    a_res_full: assert property (p_res_full) else $error("full step increment wrong");
    property p_dir_fwd;
        @(posedge aclk) disable iff (!aresetn)
            step_rise && !dir_s |=> position == $past(position) + 10'($past(incr));
    endproperty
    a_dir_fwd: assert property (p_dir_fwd) else $error("low way-select did not count up");
    property p_table_zero;
        @(posedge aclk) disable iff (!aresetn)
            position == '0 && run ##1 $stable(position) |-> coil_a.mag == 8'h00 && coil_b.mag != 8'h00;
    endproperty
    a_table_zero: assert property (p_table_zero) else $error("table origin setpoints wrong");
    property p_idle_gate;
        @(posedge aclk) disable iff (!aresetn)
            scale < sdms_pkg::SCALE_FULL |->
                $past(strap_s.cfg[4]) && $past(idle_cnt) > 32'(STANDBY_DELAY);
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("reduction before idle delay");
    property p_ramp_soft;
        @(posedge aclk) disable iff (!aresetn)
            standby && $past(standby) |-> scale + 9'h001 >= $past(scale) && scale >= sdms_pkg::SCALE_MIN;
    endproperty
    a_ramp_soft: assert property (p_ramp_soft) else $error("current scale jumped");
    property p_disable;
        @(posedge aclk) disable iff (!aresetn) strap_s.disable_drv |=> !drive_enable && coil_a == '0;
    endproperty
    a_disable: assert property (p_disable) else $error("outputs active while disabled");
    property p_fault_pin;
        @(posedge aclk) disable iff (!aresetn) |fault_s |=> ##1 error_oe && !drive_enable;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault not reported");
    property p_index_pin;
        @(posedge aclk) disable iff (!aresetn) position == '0 |=> index_oe;
    endproperty
    a_index_pin: assert property (p_index_pin) else $error("index not driven at origin");
endmodule // sdms_sequencer
`default_nettype wire

//--- sdms_step_source.sv
// motion controller model issuing step pulses and a way level
// assumes the bench calls pulse() and shares aclk with the design
`timescale 1ns/1ps
`default_nettype none
module sdms_step_source (
    input wire logic aclk,
    output logic step_pin,
    output logic dir_pin
);
    initial begin
        step_pin = 1'b0;
        dir_pin = 1'b0;
    end
    // ==============================
    // one step pulse
    task automatic pulse(input logic way, input int hold);
        @(posedge aclk);
        dir_pin <= way;
        repeat (4) @(posedge aclk);
        step_pin <= 1'b1;
        repeat (hold) @(posedge aclk);
        step_pin <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
endmodule // sdms_step_source
`default_nettype wire

//--- sdms_sequencer_bench.sv
// self-checking bench for the step/dir microstep sequencer
// assumes sdms_pkg, sdms_sequencer and sdms_step_source compiled first
`timescale 1ns/1ps
`default_nettype none
module sdms_sequencer_bench;
    localparam int DLY = 50;
    localparam int RMP = 338;
    localparam logic [3:0] A_POS = sdms_pkg::REG_POSITION;
    localparam logic [3:0] A_STS = sdms_pkg::REG_IRQ_STATUS;
    localparam logic [3:0] A_MSK = sdms_pkg::REG_IRQ_MASK;
    logic aclk, aresetn, step, dir, ext_clk;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, rs;
    sdms_pkg::sdms_strap_t straps;
    sdms_pkg::sdms_fault_t faults;
    sdms_pkg::sdms_coil_t coil_a, coil_b;
    logic drv_en, clk_sel, err_out, err_oe, idx_out, idx_oe, irq;
    logic [9:0] pos, inc;
    int fail_count;
    int checks_done;

    sdms_sequencer #(.STANDBY_DELAY(DLY), .RAMP_TOTAL(RMP)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .step_pin(step), .dir_pin(dir), .ext_clk_pin(ext_clk),
        .strap_pins(straps), .fault_pins(faults), .coil_a(coil_a), .coil_b(coil_b),
        .drive_enable(drv_en), .ext_clock_sel(clk_sel), .error_out(err_out),
        .error_oe(err_oe), .index_out(idx_out), .index_oe(idx_oe), .irq(irq)
    );
    sdms_step_source u_src (.aclk(aclk), .step_pin(step), .dir_pin(dir));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("[FAIL] watchdog expected end seen hang");
        tally_and_finish();
    end
    // ==============================
    // compare, verdict, bus cycles
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 1000);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 1000) chk("write answer", 32'h0, 32'h1);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 1000);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 1000) chk("read answer", 32'h0, 32'h1);
    endtask
    task automatic strap(input logic [6:0] v);
        @(posedge aclk);
        straps <= v;
        tick(6);
    endtask
    task automatic rd_pos;
        rd(A_POS);
        tick(1);
    endtask
    // ==============================
    // test sequence
    initial begin
        aresetn = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = 32'h0000_0000;
        ext_clk = 1'b0;
        straps = 7'h00;
        faults = 3'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        tick(4);
        rd_pos();
        chk("reset position", rv, 32'h0100_0000);
        rd(A_MSK);
        chk("reset mask", rv, 32'h0000_0000);
        chk("drive on", 32'({drv_en, err_oe, err_out}), 32'h4);
        chk("index at zero", 32'(idx_oe), 32'h1);
        chk("index pin low", 32'(idx_out), 32'h0);
        chk("sine at zero", 32'(coil_a.mag), 32'h0);
        $display("test reset done");
        u_src.pulse(1'b0, 1);
        tick(2);
        chk("cosine at quarter", 32'(coil_b.mag), 32'h0);
        chk("sine at quarter", 32'({coil_a.neg, coil_a.mag != 8'h00}), 32'h1);
        chk("index away", 32'(idx_oe), 32'h0);
        u_src.pulse(1'b0, 6);
        tick(2);
        chk("sine at half", 32'(coil_a.mag), 32'h0);
        chk("cosine sign", 32'(coil_b.neg), 32'h1);
        u_src.pulse(1'b1, 1);
        u_src.pulse(1'b1, 6);
        tick(2);
        chk("index back", 32'(idx_oe), 32'h1);
        $display("test table done");
        wr(A_MSK, 32'h0000_0002);
        rd(A_MSK);
        chk("mask back", rv, 32'h0000_0002);
        tick(2);
        chk("irq index", 32'(irq), 32'h1);
        u_src.pulse(1'b0, 1);
        wr(A_STS, 32'h0000_0002);
        rd(A_STS);
        chk("status cleared", rv & 32'h0000_0002, 32'h0);
        tick(2);
        chk("irq cleared", 32'(irq), 32'h0);
        wr(A_POS, 32'h0000_0000);
        chk("read-only", 32'(rs), 32'(sdms_pkg::RESP_DECERR));
        rd_pos();
        chk("position kept", 32'(rv[9:0]), 32'h100);
        $display("test irq done");
        pos = 10'h100;
        for (int c = 0; c < 10; c++) begin
            inc = (c == 0) ? 10'h100 : (c <= 8) ? 10'(256 >> c) : 10'h001;
            strap(7'(c));
            u_src.pulse(1'b0, 1);
            pos = pos + inc;
            rd_pos();
            chk("step up", 32'(rv[9:0]), 32'(pos));
            u_src.pulse(1'b1, 6);
            u_src.pulse(1'b1, 1);
            pos = pos - inc - inc;
            rd_pos();
            chk("step down", 32'(rv[9:0]), 32'(pos));
        end
        $display("test resolution done");
        strap(7'h2A);
        rd(sdms_pkg::REG_STRAPS);
        chk("straps", rv & 32'h0000_03FF, 32'h0000_00AA);
        wr(A_STS, 32'h0000_0007);
        for (int f = 0; f < 3; f++) begin
            @(posedge aclk);
            faults <= 3'(1 << f);
            tick(6);
            chk("fault stops drive", 32'({err_oe, drv_en}), 32'h2);
            @(posedge aclk);
            faults <= 3'h0;
            tick(6);
            chk("fault latched", 32'(err_oe), 32'h1);
            rd(A_STS);
            chk("fault event", rv & 32'h0000_0001, 32'h1);
            chk("fault masked", 32'(irq), 32'h0);
            wr(A_STS, 32'h0000_0001);
            strap(7'h40);
            chk("disabled", 32'({err_oe, drv_en}), 32'h0);
            strap(7'h00);
            chk("enabled", 32'({err_oe, drv_en, err_out}), 32'h2);
        end
        $display("test fault done");
        strap(7'h10);
        u_src.pulse(1'b0, 1);
        tick(10);
        rd_pos();
        chk("full scale", 32'(rv[24:16]), 32'h100);
        tick(DLY + 100);
        rd_pos();
        chk("ramping", 32'(rv[24:16] > 9'h057 && rv[24:16] < 9'h100), 32'h1);
        tick(RMP);
        rd_pos();
        chk("reduced", 32'(rv[24:16]), 32'(sdms_pkg::SCALE_MIN));
        rd(A_STS);
        chk("standby event", rv & 32'h0000_0004, 32'h4);
        u_src.pulse(1'b1, 1);
        rd_pos();
        chk("step restores", 32'(rv[24:16]), 32'h100);
        strap(7'h00);
        tick(DLY + RMP + 50);
        rd_pos();
        chk("option off", 32'(rv[24:16]), 32'h100);
        $display("test standstill done");
        chk("internal clock", 32'(clk_sel), 32'h0);
        repeat (40) begin
            @(posedge aclk);
            ext_clk <= ~ext_clk;
        end
        tick(1);
        chk("external clock", 32'(clk_sel), 32'h1);
        tick(100);
        chk("clock lost", 32'(clk_sel), 32'h0);
        $display("test clock done");
        tally_and_finish();
    end
endmodule // sdms_sequencer_bench
`default_nettype wire
